//--- inc/adc_mux_consts.vh
// Constants for the dual converter digital output path.
`ifndef ADC_MUX_CONSTS_VH
`define ADC_MUX_CONSTS_VH
`define ADC_WORD_W 10
`define ADC_MSB 9
`define ADC_PIPE_DEPTH 6
`define ADC_AXI_AW 4
`define REG_CTRL_OFS 4'h0
`define REG_STAT_OFS 4'h4
`define REG_CNT_OFS 4'h8
`define CTRL_FMT_BIT 0
`define CTRL_DCS_BIT 1
`define CTRL_PDA_BIT 2
`define CTRL_PDB_BIT 3
`define CTRL_OEA_BIT 4
`define CTRL_OEB_BIT 5
`define CTRL_RESET_VAL 32'h00000000
`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_DECERR 2'b11
`endif

//--- hdl/adc_sample_pipe.v
// Six-stage latency pipeline for one converter channel.
`timescale 1ns/10ps
`default_nettype none
`include "adc_mux_consts.vh"
module adc_sample_pipe (
    input wire aclk,
    input wire aresetn,
    input wire sample_en,
    input wire power_down,
    input wire [`ADC_MSB:0] sample_in,
    output wire [`ADC_MSB:0] word_out
);
    reg [`ADC_MSB:0] stage_r [0:`ADC_PIPE_DEPTH-1];
    integer i;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (i = 0; i < `ADC_PIPE_DEPTH; i = i + 1)
                stage_r[i] <= 10'h000;
        end
        else if (sample_en && !power_down)
        begin
            stage_r[0] <= sample_in;
            for (i = 1; i < `ADC_PIPE_DEPTH; i = i + 1)
                stage_r[i] <= stage_r[i-1];
        end
    end
    assign word_out = stage_r[`ADC_PIPE_DEPTH-1];
endmodule // adc_sample_pipe
`default_nettype wire

//--- hdl/adc_clock_shaper.v
// Sample clock edge detector and duty cycle regenerator for one channel.
`timescale 1ns/10ps
`default_nettype none
module adc_clock_shaper (
    input wire aclk,
    input wire aresetn,
    input wire clk_pin,
    input wire stabilize,
    output wire rise_pulse,
    output wire fall_pulse,
    output reg phase_r
);
    reg sync1_r;
    reg sync2_r;
    reg prev_r;
    reg [7:0] hi_cnt_r;
    reg [7:0] per_cnt_r;
    reg [7:0] half_r;
    wire raw_rise;
    wire raw_fall;
    wire dcs_fall;
    assign raw_rise = sync2_r && !prev_r;
    assign raw_fall = !sync2_r && prev_r;
    assign dcs_fall = (per_cnt_r != 8'h00) && (hi_cnt_r == half_r);
    assign rise_pulse = raw_rise;
    assign fall_pulse = stabilize ? dcs_fall : raw_fall;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
            hi_cnt_r <= 8'h00;
            per_cnt_r <= 8'h00;
            half_r <= 8'h00;
            phase_r <= 1'b0;
        end
        else
        begin
            sync1_r <= clk_pin;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
            if (raw_rise)
            begin
                half_r <= {1'b0, per_cnt_r[7:1]};
                per_cnt_r <= 8'h01;
                hi_cnt_r <= 8'h01;
            end
            else
            begin
                if (per_cnt_r != 8'hff)
                    per_cnt_r <= per_cnt_r + 8'h01;
                if (hi_cnt_r != 8'hff)
                    hi_cnt_r <= hi_cnt_r + 8'h01;
            end
            if (raw_rise)
                phase_r <= 1'b1;
            else if (fall_pulse)
                phase_r <= 1'b0;
        end
    end
endmodule // adc_clock_shaper
`default_nettype wire

//--- hdl/dual_adc_output_mux.v
// Digital output path of a dual 10-bit sampling converter.
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "adc_mux_consts.vh"
//Contract
// - Each result appears on the output bus six sample clocks after sampling; the bus here takes it on the seventh rising edge.
// - Output words change just after a rising sample clock edge.
// - With the stabilizer on, the internal clock is rebuilt at 50% duty.
// - Each channel yields a 10-bit word and both may share one 10-bit bus.
// - Format select low gives offset binary words.
// - Format select high gives twos complement, the MSB inverted.
// - Swap select high routes channel A to bus A and B to bus B.
// - Swap select low routes channel A to bus B and B to bus A.
// - With the clock on swap select, own word after rise, other after fall.
// - Multiplexed buses carry interleaved words at twice the sample rate.
// - Each channel stands by on its own power-down input.
module dual_adc_output_mux (
    input wire aclk,
    input wire aresetn,
    input wire sample_clk_a,
    input wire sample_clk_b,
    input wire channel_swap_select,
    input wire [9:0] sample_a,
    input wire [9:0] sample_b,
    output reg [9:0] bus_a_out,
    output wire [9:0] bus_a_oe,
    output reg [9:0] bus_b_out,
    output wire [9:0] bus_b_oe,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    // ----------------------------------------------------------------
    // Register slave
    // ----------------------------------------------------------------
    reg [31:0] ctrl_r;
    reg aw_held_r;
    reg w_held_r;
    reg [3:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg [15:0] word_cnt_r;
    wire output_format_select;
    wire duty_cycle_stabilizer_enable;
    wire power_down_a;
    wire power_down_b;
    wire output_enable_n_a;
    wire output_enable_n_b;
    wire do_write;
    integer k;
    assign output_format_select = ctrl_r[`CTRL_FMT_BIT];
    assign duty_cycle_stabilizer_enable = ctrl_r[`CTRL_DCS_BIT];
    assign power_down_a = ctrl_r[`CTRL_PDA_BIT];
    assign power_down_b = ctrl_r[`CTRL_PDB_BIT];
    assign output_enable_n_a = ctrl_r[`CTRL_OEA_BIT];
    assign output_enable_n_b = ctrl_r[`CTRL_OEB_BIT];
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r <= `CTRL_RESET_VAL;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 4'h0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AXI_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if ({awaddr_r[3:2], 2'b00} == `REG_CTRL_OFS)
                begin
                    s_axi_bresp <= `AXI_RESP_OKAY;
                    for (k = 0; k < 4; k = k + 1)
                        if (wstrb_r[k])
                            ctrl_r[k*8 +: 8] <= wdata_r[k*8 +: 8];
                end
                else if ({awaddr_r[3:2], 2'b00} == `REG_STAT_OFS ||
                         {awaddr_r[3:2], 2'b00} == `REG_CNT_OFS)
                    s_axi_bresp <= `AXI_RESP_OKAY;
                else
                    s_axi_bresp <= `AXI_RESP_DECERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Sample clocks and channel pipelines
    // ----------------------------------------------------------------
    wire rise_a;
    wire fall_a;
    wire phase_a;
    wire rise_b;
    wire fall_b;
    wire phase_b;
    wire [9:0] word_a;
    wire [9:0] word_b;
    reg swap_s1_r;
    reg swap_s2_r;
    reg [9:0] samp_a_s1_r;
    reg [9:0] samp_a_s2_r;
    reg [9:0] samp_b_s1_r;
    reg [9:0] samp_b_s2_r;

    adc_clock_shaper shaper_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_pin(sample_clk_a),
        .stabilize(duty_cycle_stabilizer_enable),
        .rise_pulse(rise_a),
        .fall_pulse(fall_a),
        .phase_r(phase_a)
    );
    adc_clock_shaper shaper_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_pin(sample_clk_b),
        .stabilize(duty_cycle_stabilizer_enable),
        .rise_pulse(rise_b),
        .fall_pulse(fall_b),
        .phase_r(phase_b)
    );

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            swap_s1_r <= 1'b0;
            swap_s2_r <= 1'b0;
            samp_a_s1_r <= 10'h000;
            samp_a_s2_r <= 10'h000;
            samp_b_s1_r <= 10'h000;
            samp_b_s2_r <= 10'h000;
        end
        else
        begin
            swap_s1_r <= channel_swap_select;
            swap_s2_r <= swap_s1_r;
            samp_a_s1_r <= sample_a;
            samp_a_s2_r <= samp_a_s1_r;
            samp_b_s1_r <= sample_b;
            samp_b_s2_r <= samp_b_s1_r;
        end
    end

    adc_sample_pipe pipe_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .sample_en(rise_a),
        .power_down(power_down_a),
        .sample_in(samp_a_s2_r),
        .word_out(word_a)
    );
    adc_sample_pipe pipe_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .sample_en(rise_b),
        .power_down(power_down_b),
        .sample_in(samp_b_s2_r),
        .word_out(word_b)
    );

    // ----------------------------------------------------------------
    // Format, routing and output latches
    // ----------------------------------------------------------------
    reg [9:0] fmt_a;
    reg [9:0] fmt_b;
    reg swap_prev_r;
    wire upd_a;
    wire upd_b;
    always @*
    begin
        fmt_a = word_a;
        fmt_b = word_b;
        if (output_format_select)
        begin
            fmt_a[`ADC_MSB] = ~word_a[`ADC_MSB];
            fmt_b[`ADC_MSB] = ~word_b[`ADC_MSB];
        end
    end
    assign upd_a = rise_a || rise_b || (swap_s2_r != swap_prev_r);
    assign upd_b = upd_a;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            swap_prev_r <= 1'b0;
            bus_a_out <= 10'h000;
            bus_b_out <= 10'h000;
            word_cnt_r <= 16'h0000;
        end
        else
        begin
            swap_prev_r <= swap_s2_r;
            if (upd_a)
            begin
                bus_a_out <= swap_s2_r ? fmt_a : fmt_b;
                bus_b_out <= swap_s2_r ? fmt_b : fmt_a;
            end
            if (rise_a)
                word_cnt_r <= word_cnt_r + 16'h0001;
        end
    end
    assign bus_a_oe = {10{~output_enable_n_a}};
    assign bus_b_oe = {10{~output_enable_n_b}};

    // ----------------------------------------------------------------
    // Register read
    // ----------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `AXI_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `AXI_RESP_OKAY;
            case (s_axi_araddr[3:2])
                2'h0: s_axi_rdata <= ctrl_r;
                2'h1: s_axi_rdata <= {28'h0000000, phase_b, phase_a,
                                      fall_a | fall_b, swap_s2_r};
                2'h2: s_axi_rdata <= {16'h0000, word_cnt_r};
                default:
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `AXI_RESP_DECERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule // dual_adc_output_mux
`default_nettype wire

//--- dv/dual_adc_output_mux_properties.sv
// Port-level checks for the dual converter output path.
`timescale 1ns/10ps
`default_nettype none
module dual_adc_output_mux_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sample_clk_a,
    input wire logic sample_clk_b,
    input wire logic channel_swap_select,
    input wire logic [9:0] bus_a_out,
    input wire logic [9:0] bus_a_oe,
    input wire logic [9:0] bus_b_oe,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    logic ca_r;
    logic cb_r;
    logic sw_r;
    logic [3:0] quiet_r;
    default clocking ck @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Counts cycles since the last event allowed to move a bus.
    always @(posedge aclk)
    begin
        ca_r <= sample_clk_a;
        cb_r <= sample_clk_b;
        sw_r <= channel_swap_select;
        if (!aresetn || (sample_clk_a && !ca_r) || (sample_clk_b && !cb_r)
            || (channel_swap_select != sw_r) || s_axi_awvalid)
            quiet_r <= 4'h0;
        else if (quiet_r != 4'hf)
            quiet_r <= quiet_r + 4'h1;
    end
    AST_OE_RESET:
        assert property (!$past(aresetn) |-> bus_a_oe == 10'h3ff
            && bus_b_oe == 10'h3ff && bus_a_out == 10'h000)
        else $error("bus state wrong after reset");
    AST_OE_WHOLE:
        assert property ((bus_a_oe == 10'h3ff || bus_a_oe == 10'h000)
            && (bus_b_oe == 10'h3ff || bus_b_oe == 10'h000))
        else $error("bus enable split across bits");
    AST_BUS_AFTER_EDGE:
        assert property ($changed(bus_a_out) |-> quiet_r <= 4'h3)
        else $error("bus word moved without a clock edge");
    AST_WRITE_ANSWER:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
            && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    AST_READ_ANSWER:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    AST_B_STANDS:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
            && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_AW_BLOCK:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    AST_AR_BLOCK:
        assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during data");
endmodule // dual_adc_output_mux_checker
bind dual_adc_output_mux dual_adc_output_mux_checker u_chk (.aclk, .aresetn,
    .sample_clk_a, .sample_clk_b, .channel_swap_select, .bus_a_out, .bus_a_oe,
    .bus_b_oe, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid);
`default_nettype wire

//--- dv/bus_capture.sv
// Downstream capture model that resolves one converter output bus.
`timescale 1ns/10ps
`default_nettype none
module bus_capture (
    input wire logic aclk,
    input wire logic [9:0] word_out,
    input wire logic [9:0] word_oe,
    output var logic [9:0] pin_level
);
    logic [9:0] last_r = 10'h000;
    // A released bit shows the inverse of its last driven level.
    always_comb
        for (int i = 0; i < 10; i++)
            pin_level[i] = word_oe[i] ? word_out[i] : ~last_r[i];
    always @(posedge aclk)
        for (int i = 0; i < 10; i++)
            if (word_oe[i])
                last_r[i] <= word_out[i];
endmodule // bus_capture
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the dual converter output path.
`timescale 1ns/10ps
`default_nettype none
`include "adc_mux_consts.vh"
module tb;
    typedef struct {
        logic [31:0] ctrl;
        logic sw;
        logic [9:0] sa, sb, ea, eb;
    } row_t;
    row_t rows [4] = '{
        '{32'h0, 1'h1, 10'h000, 10'h3ff, 10'h000, 10'h3ff},
        '{32'h0, 1'h0, 10'h0c3, 10'h2a5, 10'h2a5, 10'h0c3},
        '{32'h1, 1'h1, 10'h1ff, 10'h200, 10'h3ff, 10'h000},
        '{32'h1, 1'h0, 10'h0c3, 10'h2a5, 10'h0a5, 10'h2c3}};
    logic aclk = 1'h0, aresetn = 1'h0, sample_clk_a = 1'h0;
    logic sample_clk_b = 1'h0, channel_swap_select = 1'h1;
    logic [9:0] sample_a = 10'h0, sample_b = 10'h0;
    logic [9:0] bus_a_out, bus_a_oe, bus_b_out, bus_b_oe, pin_a, pin_b;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, stop_a = 1'h0, mux = 1'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    int fail_count = 0, checked = 0, cycles = 0;
    dual_adc_output_mux u_dual_adc_output_mux (.aclk, .aresetn, .sample_clk_a,
        .sample_clk_b, .channel_swap_select, .sample_a, .sample_b, .bus_a_out,
        .bus_a_oe, .bus_b_out, .bus_b_oe, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    bus_capture u_bus_capture_a (.aclk, .word_out(bus_a_out),
        .word_oe(bus_a_oe), .pin_level(pin_a));
    bus_capture u_bus_capture_b (.aclk, .word_out(bus_b_out),
        .word_oe(bus_b_oe), .pin_level(pin_b));
    always #10 aclk = ~aclk;
    task automatic wrap_up;
        if (fail_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic check(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic pins(input string n, input logic [9:0] ea, eb);
        @(negedge aclk);
        check({n, "_a"}, {22'h0, pin_a}, {22'h0, ea});
        check({n, "_b"}, {22'h0, pin_b}, {22'h0, eb});
    endtask
    task automatic half(input logic v);
        @(posedge aclk);
        if (!stop_a)
            sample_clk_a <= v;
        sample_clk_b <= v;
        if (mux)
            channel_swap_select <= v;
        repeat (7) @(posedge aclk);
    endtask
    task automatic tick(input int n);
        repeat (n)
        begin
            half(1'h1);
            half(1'h0);
        end
    endtask
    task automatic put(input logic [9:0] a, b);
        @(posedge aclk);
        sample_a <= a;
        sample_b <= b;
        repeat (3) @(posedge aclk);
    endtask
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end while ((s_axi_awvalid && !s_axi_awready)
            || (s_axi_wvalid && !s_axi_wready));
        repeat (4) @(posedge aclk);
        s_axi_bready <= 1'h1;
        do @(posedge aclk); while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic axi_read(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        check("oe_a", {22'h0, bus_a_oe}, 32'h3ff);
        axi_read(`REG_CTRL_OFS);
        check("ctrl", rd, `CTRL_RESET_VAL);
        axi_read(4'hc);
        check("unmapped", {30'h0, rs}, {30'h0, `AXI_RESP_DECERR});
        foreach (rows[i])
        begin
            axi_write(`REG_CTRL_OFS, rows[i].ctrl);
            channel_swap_select <= rows[i].sw;
            put(rows[i].sa, rows[i].sb);
            tick(7);
            pins("row", rows[i].ea, rows[i].eb);
        end
        axi_write(`REG_CTRL_OFS, 32'h0);
        channel_swap_select <= 1'h1;
        put(10'h111, 10'h222);
        tick(7);
        put(10'h333, 10'h222);
        tick(5);
        pins("lat5", 10'h111, 10'h222);
        tick(2);
        pins("lat7", 10'h333, 10'h222);
        axi_write(`REG_CTRL_OFS, 32'h4);
        put(10'h155, 10'h0aa);
        tick(7);
        pins("pdwn", 10'h333, 10'h0aa);
        stop_a = 1'h1;
        axi_write(`REG_CTRL_OFS, 32'h6);
        put(10'h0f0, 10'h10f);
        tick(7);
        pins("pdwn_dcs", 10'h333, 10'h10f);
        axi_write(`REG_CTRL_OFS, 32'h2);
        repeat (3)
        begin
            @(posedge aclk);
            sample_clk_a <= 1'h1;
            repeat (2) @(posedge aclk);
            sample_clk_a <= 1'h0;
            repeat (14) @(posedge aclk);
        end
        @(posedge aclk);
        sample_clk_a <= 1'h1;
        repeat (2) @(posedge aclk);
        sample_clk_a <= 1'h0;
        repeat (3) @(posedge aclk);
        axi_read(`REG_STAT_OFS);
        check("dcs_phase", {31'h0, rd[2]}, 32'h1);
        axi_write(4'hc, 32'h0);
        check("wr_unmapped", {30'h0, rs}, {30'h0, `AXI_RESP_DECERR});
        axi_write(`REG_CTRL_OFS, 32'h20);
        stop_a = 1'h0;
        put(10'h101, 10'h202);
        tick(7);
        mux = 1'h1;
        repeat (2)
        begin
            half(1'h1);
            @(negedge aclk);
            check("mux_own", {22'h0, pin_a}, 32'h101);
            half(1'h0);
            @(negedge aclk);
            check("mux_other", {22'h0, pin_a}, 32'h202);
        end
        check("oe_b", {22'h0, bus_b_oe}, 32'h0);
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(negedge aclk);
        check("oe_b_rst", {22'h0, bus_b_oe}, 32'h3ff);
        check("pin_b_rst", {22'h0, pin_b}, 32'h0);
        axi_read(`REG_CTRL_OFS);
        check("ctrl_rst", rd, `CTRL_RESET_VAL);
        wrap_up();
    end
endmodule // tb
`default_nettype wire
